// ---- rxscw_control_word.sv ----
// Serial-programmed 32-bit receiver control word with readback and pin decode
module rxscw_control_word
    import rxscw_pkg::*;
#(
    parameter int unsigned NUM_CHANNELS = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Serial link pins
    input wire logic i_select_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_in_pin,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    // Saturation detectors, one per channel
    input wire logic [NUM_CHANNELS-1:0] i_sat_detect,
    // Shared analog pin control
    output logic o_sat_flag,
    output logic o_sat_flag_oe,
    output logic o_shared_analog_pin_en,
    output logic o_route_temp,
    output logic o_route_power,
    output logic o_route_bandgap,
    output logic o_route_valid,
    output logic o_probe_lo_power,
    output logic o_probe_valid,
    // Receiver pair A (receivers 1 and 2)
    output logic o_pair_a_enable,
    output logic o_pair_a_amp1_gain6,
    output logic o_pair_a_amp1_gain12,
    output logic o_pair_a_amp2_gain6,
    output logic o_pair_a_amp2_gain12,
    output logic o_pair_a_amp2_gain18,
    // Receiver pair B (receivers 3 and 4)
    output logic o_pair_b_enable,
    output logic o_pair_b_amp1_gain6,
    output logic o_pair_b_amp1_gain12,
    output logic o_pair_b_amp2_gain6,
    output logic o_pair_b_amp2_gain12,
    output logic o_pair_b_amp2_gain18,
    // Test signal injection
    output logic o_test_inject_ch1,
    output logic o_test_inject_ch2,
    output logic o_test_inject_ch3,
    output logic o_test_inject_ch4,
    // Selector fields and test bits as stored
    output logic [2:0] o_analog_select,
    output logic [1:0] o_power_probe_select,
    output logic o_flag_release_mux_on,
    output logic [5:0] o_test_bits_low,
    output logic o_test_bit_26,
    output logic [2:0] o_test_bits_high,
    // Whole word for observation
    output logic [WORD_WIDTH-1:0] o_receiver_control_word
);

    // ==========================================================
    // Decoding helpers
    function automatic logic is_temp_code(input logic [2:0] code);
        is_temp_code = (code == ANALOG_TEMP_0) || (code == ANALOG_TEMP_1);
    endfunction : is_temp_code

    function automatic logic is_valid_route(input logic [2:0] code);
        is_valid_route = is_temp_code(code) || (code == ANALOG_POWER) ||
                         (code == ANALOG_BANDGAP);
    endfunction : is_valid_route

    // ==========================================================
    // Pin synchronisation
    // All three pins idle high behind pull-ups, so every stage resets high;
    // a low reset value would fake an edge on the first cycle after reset.
    logic [2:0] pins_s;
    logic sel_s;
    logic sclk_s;
    logic din_s;

    rxscw_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'h7)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_select_n, i_serial_clk, i_serial_in_pin}),
        .o_sync(pins_s)
    );

    assign sel_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    logic [NUM_CHANNELS-1:0] sat_s;

    rxscw_sync #(
        .WIDTH(NUM_CHANNELS),
        .RESET_VALUE('0)
    ) u_sat_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_sat_detect),
        .o_sync(sat_s)
    );

    // ==========================================================
    // Edge detection
    logic sel_prev_q;
    logic sclk_prev_q;
    logic din_prev_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sel_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
            din_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= sel_s;
            sclk_prev_q <= sclk_s;
            din_prev_q <= din_s;
        end
    end

    logic start_cmd;
    logic end_cmd;
    logic sclk_fall;
    logic din_sample;

    assign start_cmd = sel_prev_q & ~sel_s;
    assign end_cmd = ~sel_prev_q & sel_s;
    // Clock edges while deselected are ignored, so stray host clocks
    // between commands never disturb the shifter.
    assign sclk_fall = sclk_prev_q & ~sclk_s & ~sel_s;
    // Last sample taken while the clock was still high; the 10 ns hold
    // after the edge is too short to rely on a later sample.
    assign din_sample = din_prev_q;

    // ==========================================================
    // Transfer state machine
    rxscw_state_type state_q;
    rxscw_state_type state_d;
    logic [WORD_WIDTH-1:0] shift_q;
    logic [WORD_WIDTH-1:0] shift_d;
    logic [WORD_WIDTH-1:0] readback_q;
    logic [WORD_WIDTH-1:0] readback_d;
    logic [COUNT_WIDTH-1:0] count_q;
    logic [COUNT_WIDTH-1:0] count_d;
    logic [WORD_WIDTH-1:0] word_q;
    logic [WORD_WIDTH-1:0] word_d;
    logic apply_word;
    logic [COUNT_WIDTH-1:0] count_inc;
    logic frame_complete;

    // Counting saturates just past a full word, so overlong frames are dropped
    assign count_inc = (count_q == COUNT_OVER) ? count_q : count_q + 6'h01;
    // A short or long frame leaves the stored word alone
    assign frame_complete = (count_q == COUNT_FULL);
    assign apply_word = (state_q == ST_SHIFT) && end_cmd && frame_complete;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        readback_d = readback_q;
        count_d = count_q;
        case (state_q)
            ST_IDLE: begin
                // Readback returns the settings in force when select fell
                if (start_cmd) begin
                    state_d = ST_SHIFT;
                    count_d = '0;
                    readback_d = word_q;
                end
            end
            ST_SHIFT: begin
                if (end_cmd) begin
                    state_d = ST_IDLE;
                end else if (sclk_fall) begin
                    shift_d = {shift_q[WORD_WIDTH-2:0], din_sample};
                    readback_d = {readback_q[WORD_WIDTH-2:0], 1'b0};
                    count_d = count_inc;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Settings hold while shifting; only a complete frame replaces them
    assign word_d = apply_word ? shift_q : word_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            shift_q <= '0;
            readback_q <= '0;
            count_q <= '0;
            word_q <= WORD_RESET;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            readback_q <= readback_d;
            count_q <= count_d;
            word_q <= word_d;
        end
    end

    // ==========================================================
    // Serial output
    // Driven only while a command is in progress; the synchroniser delay
    // keeps the release well under 100 ns.
    assign o_serial_out = readback_q[WORD_WIDTH-1];
    assign o_serial_out_oe = (state_q == ST_SHIFT);

    // ==========================================================
    // Receiver controls
    // Every control is a plain bit of the stored word
    assign o_pair_b_enable = word_q[POS_PAIR_B_ENABLE];
    assign o_pair_a_enable = word_q[POS_PAIR_A_ENABLE];
    assign o_pair_b_amp1_gain6 = word_q[POS_PAIR_B_AMP1_GAIN6];
    assign o_pair_b_amp1_gain12 = word_q[POS_PAIR_B_AMP1_GAIN12];
    assign o_pair_a_amp1_gain6 = word_q[POS_PAIR_A_AMP1_GAIN6];
    assign o_pair_a_amp1_gain12 = word_q[POS_PAIR_A_AMP1_GAIN12];
    assign o_pair_b_amp2_gain6 = word_q[POS_PAIR_B_AMP2_GAIN6];
    assign o_pair_b_amp2_gain12 = word_q[POS_PAIR_B_AMP2_GAIN12];
    assign o_pair_b_amp2_gain18 = word_q[POS_PAIR_B_AMP2_GAIN18];
    assign o_pair_a_amp2_gain6 = word_q[POS_PAIR_A_AMP2_GAIN6];
    assign o_pair_a_amp2_gain12 = word_q[POS_PAIR_A_AMP2_GAIN12];
    assign o_pair_a_amp2_gain18 = word_q[POS_PAIR_A_AMP2_GAIN18];

    // Channel order is reversed against bit order
    assign o_test_inject_ch4 = word_q[POS_TEST_INJECT_CH4];
    assign o_test_inject_ch3 = word_q[POS_TEST_INJECT_CH3];
    assign o_test_inject_ch2 = word_q[POS_TEST_INJECT_CH2];
    assign o_test_inject_ch1 = word_q[POS_TEST_INJECT_CH1];

    assign o_test_bits_low = word_q[POS_TEST_LOW_MSB:POS_TEST_LOW_LSB];
    assign o_test_bit_26 = word_q[POS_TEST_BIT_26];
    assign o_test_bits_high = word_q[POS_TEST_HIGH_MSB:POS_TEST_HIGH_LSB];
    assign o_receiver_control_word = word_q;

    // ==========================================================
    // Analog selector and power probe
    logic [2:0] analog_code;
    logic [1:0] probe_code;

    assign analog_code = word_q[POS_ANALOG_SELECT_MSB:POS_ANALOG_SELECT_LSB];
    assign probe_code = word_q[POS_POWER_PROBE_MSB:POS_POWER_PROBE_LSB];
    assign o_analog_select = analog_code;
    assign o_power_probe_select = probe_code;

    assign o_route_temp = is_temp_code(analog_code);
    assign o_route_power = (analog_code == ANALOG_POWER);
    assign o_route_bandgap = (analog_code == ANALOG_BANDGAP);
    assign o_route_valid = is_valid_route(analog_code);
    assign o_probe_lo_power = (probe_code == PROBE_LO_POWER);
    assign o_probe_valid = (probe_code == PROBE_LO_POWER);

    // ==========================================================
    // Saturation flag and shared pin
    logic sat_flag_q;

    // Registered OR keeps decode glitches off the pin
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sat_flag_q <= 1'b0;
        end else begin
            sat_flag_q <= |sat_s;
        end
    end

    assign o_flag_release_mux_on = word_q[POS_FLAG_RELEASE_MUX_ON];
    assign o_sat_flag = sat_flag_q;
    // Pin is never driven by both sources at once
    // Ownership follows bit 25 even when the selector code is invalid
    assign o_sat_flag_oe = ~word_q[POS_FLAG_RELEASE_MUX_ON];
    assign o_shared_analog_pin_en = word_q[POS_FLAG_RELEASE_MUX_ON];

endmodule : rxscw_control_word

// ---- rxscw_pkg.sv ----
// Constants and types shared by the receiver serial control word logic
package rxscw_pkg;

    // ==========================================================
    // Control word geometry
    localparam int unsigned WORD_WIDTH = 32;
    localparam int unsigned COUNT_WIDTH = 6;
    localparam logic [5:0] COUNT_FULL = 6'h20;
    localparam logic [5:0] COUNT_OVER = 6'h21;
    localparam logic [31:0] WORD_RESET = 32'h0000_cc00;

    // ==========================================================
    // Field positions within the control word
    localparam int unsigned POS_PAIR_B_ENABLE = 0;
    localparam int unsigned POS_PAIR_B_AMP1_GAIN6 = 1;
    localparam int unsigned POS_PAIR_B_AMP1_GAIN12 = 2;
    localparam int unsigned POS_PAIR_B_AMP2_GAIN6 = 3;
    localparam int unsigned POS_PAIR_B_AMP2_GAIN12 = 4;
    localparam int unsigned POS_PAIR_B_AMP2_GAIN18 = 5;
    localparam int unsigned POS_TEST_INJECT_CH4 = 6;
    localparam int unsigned POS_TEST_INJECT_CH3 = 7;
    localparam int unsigned POS_TEST_INJECT_CH2 = 8;
    localparam int unsigned POS_TEST_INJECT_CH1 = 9;
    localparam int unsigned POS_TEST_LOW_LSB = 10;
    localparam int unsigned POS_TEST_LOW_MSB = 15;
    localparam int unsigned POS_PAIR_A_ENABLE = 16;
    localparam int unsigned POS_PAIR_A_AMP1_GAIN6 = 17;
    localparam int unsigned POS_PAIR_A_AMP1_GAIN12 = 18;
    localparam int unsigned POS_PAIR_A_AMP2_GAIN6 = 19;
    localparam int unsigned POS_PAIR_A_AMP2_GAIN12 = 20;
    localparam int unsigned POS_PAIR_A_AMP2_GAIN18 = 21;
    localparam int unsigned POS_ANALOG_SELECT_LSB = 22;
    localparam int unsigned POS_ANALOG_SELECT_MSB = 24;
    localparam int unsigned POS_FLAG_RELEASE_MUX_ON = 25;
    localparam int unsigned POS_TEST_BIT_26 = 26;
    localparam int unsigned POS_POWER_PROBE_LSB = 27;
    localparam int unsigned POS_POWER_PROBE_MSB = 28;
    localparam int unsigned POS_TEST_HIGH_LSB = 29;
    localparam int unsigned POS_TEST_HIGH_MSB = 31;

    // ==========================================================
    // Analog selector and power probe codes
    localparam logic [2:0] ANALOG_TEMP_0 = 3'h0;
    localparam logic [2:0] ANALOG_TEMP_1 = 3'h1;
    localparam logic [2:0] ANALOG_POWER = 3'h2;
    localparam logic [2:0] ANALOG_BANDGAP = 3'h4;
    localparam logic [1:0] PROBE_LO_POWER = 2'h0;

    // ==========================================================
    // Link timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned T_MSB_VALID_NS = 90;
    localparam int unsigned T_BIT_VALID_NS = 30;
    localparam int unsigned T_RELEASE_NS = 100;
    localparam int unsigned T_MSB_VALID_CYC = T_MSB_VALID_NS / CLK_PERIOD_NS;
    localparam int unsigned T_BIT_VALID_CYC = T_BIT_VALID_NS / CLK_PERIOD_NS;
    localparam int unsigned T_RELEASE_CYC = T_RELEASE_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Transfer state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } rxscw_state_type;

endpackage : rxscw_pkg

// ---- rxscw_sync.sv ----
// Two flip-flop synchroniser for pins from outside the clock domain
module rxscw_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Asynchronous inputs
    input wire logic [WIDTH-1:0] i_async,
    // Synchronised outputs
    output logic [WIDTH-1:0] o_sync
);

    // ==========================================================
    // Metastability stages
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Only the second stage is visible outside
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : rxscw_sync

// ---- rxscw_control_word_sva.sv ----
// Port-level assertions for the receiver serial control word
module rxscw_control_word_sva
    import rxscw_pkg::*;
#(
    parameter int unsigned NUM_CHANNELS = 4
) (
    // Clock, reset and inputs
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_select_n,
    input wire logic [NUM_CHANNELS-1:0] i_sat_detect,
    // Outputs under watch
    input wire logic o_serial_out,
    input wire logic o_serial_out_oe,
    input wire logic o_sat_flag,
    input wire logic o_sat_flag_oe,
    input wire logic o_shared_analog_pin_en,
    input wire logic o_route_temp,
    input wire logic o_route_power,
    input wire logic o_route_bandgap,
    input wire logic o_route_valid,
    input wire logic o_probe_valid,
    input wire logic o_test_inject_ch1,
    input wire logic o_test_inject_ch4,
    input wire logic [WORD_WIDTH-1:0] o_receiver_control_word
);
    // ======
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire [2:0] sel_code = o_receiver_control_word[24:22];

    a_flag_pin_swap: assert property (
        o_sat_flag_oe == !o_receiver_control_word[25]
        && o_shared_analog_pin_en == o_receiver_control_word[25])
        else $error("shared pin owner wrong");
    a_inject_order: assert property (
        o_test_inject_ch1 == o_receiver_control_word[9]
        && o_test_inject_ch4 == o_receiver_control_word[6]) else $error("inject order wrong");
    a_route_decode: assert property (
        {o_route_bandgap, o_route_power, o_route_temp}
        == {sel_code == 3'h4, sel_code == 3'h2, sel_code[2:1] == 2'h0})
        else $error("selector decode wrong");
    a_route_valid: assert property (
        o_route_valid == (o_route_temp | o_route_power | o_route_bandgap))
        else $error("selector valid wrong");
    a_probe_decode: assert property (
        o_probe_valid == (o_receiver_control_word[28:27] == 2'h0)) else $error("probe decode wrong");
    // Five steady samples cover the synchroniser and the output register
    a_sat_merge: assert property (
        $stable(i_sat_detect) [*5] |-> o_sat_flag == (|i_sat_detect)) else $error("sat flag wrong");
    a_oe_start: assert property (
        $fell(i_select_n) |-> ##[1:9] o_serial_out_oe) else $error("serial out late");
    a_oe_release: assert property (
        $rose(i_select_n) |-> ##[1:10] !o_serial_out_oe) else $error("serial out not released");
    a_msb_first: assert property (
        $rose(o_serial_out_oe) |-> !i_select_n && o_serial_out == o_receiver_control_word[31])
        else $error("first readback bit wrong");
    a_word_hold: assert property (
        $changed(o_receiver_control_word) |-> $fell(o_serial_out_oe)) else $error("word changed early");

    c_word_load: cover property ($fell(o_serial_out_oe) && $changed(o_receiver_control_word));
    c_bandgap: cover property (o_route_bandgap);
    c_sat_flag: cover property (o_sat_flag);
endmodule : rxscw_control_word_sva

bind rxscw_control_word rxscw_control_word_sva #(.NUM_CHANNELS(NUM_CHANNELS))
    rxscw_control_word_sva_inst (
    .i_clk, .i_reset, .i_select_n, .i_sat_detect, .o_serial_out, .o_serial_out_oe,
    .o_sat_flag, .o_sat_flag_oe, .o_shared_analog_pin_en, .o_route_temp, .o_route_power,
    .o_route_bandgap, .o_route_valid, .o_probe_valid, .o_test_inject_ch1,
    .o_test_inject_ch4, .o_receiver_control_word
);

// ---- rxscw_host_model.sv ----
// Serial host model driving select, link clock and data for the control word
module rxscw_host_model (
    // Readback from the device
    input wire logic i_serial_out,
    input wire logic i_serial_out_oe,
    // Link pins toward the device
    output logic o_select_n,
    output logic o_serial_clk,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released line reads inverted so a missing drive cannot pass
    wire line_level = i_serial_out_oe ? i_serial_out : !i_serial_out;

    // Pull-ups hold all three pins high while idle
    initial begin
        o_select_n = 1'b1;
        o_serial_clk = 1'b1;
        o_serial_in = 1'b1;
    end

    // ======
    // One frame of nbits, first bit from wr[nbits-1]
    task automatic xfer(input logic [39:0] wr, input int nbits, output logic [31:0] rd);
        rd = '0;
        o_select_n = 1'b0;
        o_serial_in = wr[nbits-1];
        #90;
        rd[31] = line_level;
        #10;
        for (int k = 0; k < nbits; k++) begin
            o_serial_clk = 1'b0;
            #30;
            if (k < 31) begin
                rd[30-k] = line_level;
            end
            #32.5;
            o_serial_clk = 1'b1;
            o_serial_in = (k < nbits - 1) ? wr[nbits-2-k] : 1'b1;
            #62.5;
        end
        o_select_n = 1'b1;
        #5000;
    endtask : xfer

    // Clock pulses with select high, which the device must ignore
    task automatic stray_clocks(input int n);
        for (int k = 0; k < n; k++) begin
            o_serial_in = k[0];
            o_serial_clk = 1'b0;
            #62.5;
            o_serial_clk = 1'b1;
            #62.5;
        end
        o_serial_in = 1'b1;
    endtask : stray_clocks
endmodule : rxscw_host_model

// ---- test_receiver_serial_control_word.sv ----
// Self-checking bench for the receiver serial control word
module test_receiver_serial_control_word import rxscw_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_sat_detect = 4'h0;
    logic [31:0] prev;
    int err_total = 0;
    int tests_run = 0;
    wire select_n, serial_clk, serial_in, serial_out, serial_out_oe;
    wire sat_flag, flag_oe, pin_en, probe_lo, probe_valid, release_bit, tb26;
    wire [3:0] rt, inj;
    wire [5:0] pa, pb, tb_low;
    wire [2:0] asel, tb_high;
    wire [1:0] psel;
    wire [31:0] word;

    always #5 i_clk = ~i_clk;

    rxscw_control_word rxscw_control_word_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_select_n(select_n), .i_serial_clk(serial_clk),
        .i_serial_in_pin(serial_in), .o_serial_out(serial_out),
        .o_serial_out_oe(serial_out_oe), .i_sat_detect(i_sat_detect), .o_sat_flag(sat_flag),
        .o_sat_flag_oe(flag_oe), .o_shared_analog_pin_en(pin_en), .o_route_temp(rt[0]),
        .o_route_power(rt[1]), .o_route_bandgap(rt[2]), .o_route_valid(rt[3]),
        .o_probe_lo_power(probe_lo), .o_probe_valid(probe_valid), .o_pair_a_enable(pa[0]),
        .o_pair_a_amp1_gain6(pa[1]), .o_pair_a_amp1_gain12(pa[2]), .o_pair_a_amp2_gain6(pa[3]),
        .o_pair_a_amp2_gain12(pa[4]), .o_pair_a_amp2_gain18(pa[5]), .o_pair_b_enable(pb[0]),
        .o_pair_b_amp1_gain6(pb[1]), .o_pair_b_amp1_gain12(pb[2]), .o_pair_b_amp2_gain6(pb[3]),
        .o_pair_b_amp2_gain12(pb[4]), .o_pair_b_amp2_gain18(pb[5]),
        .o_test_inject_ch1(inj[0]), .o_test_inject_ch2(inj[1]), .o_test_inject_ch3(inj[2]),
        .o_test_inject_ch4(inj[3]), .o_analog_select(asel), .o_power_probe_select(psel),
        .o_flag_release_mux_on(release_bit), .o_test_bits_low(tb_low), .o_test_bit_26(tb26),
        .o_test_bits_high(tb_high), .o_receiver_control_word(word)
    );

    rxscw_host_model rxscw_host_model_inst (
        .i_serial_out(serial_out), .i_serial_out_oe(serial_out_oe),
        .o_select_n(select_n), .o_serial_clk(serial_clk), .o_serial_in(serial_in)
    );

    // ======
    // Comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check_all(input logic [31:0] w);
        logic [2:0] v;
        v = {w[24:22] == 3'h4, w[24:22] == 3'h2, w[24:23] == 2'h0};
        check(word, w);
        check(pb, w[5:0]);
        check(pa, w[21:16]);
        check(inj, {w[6], w[7], w[8], w[9]});
        check(rt, {|v, v});
        check({asel, psel}, {w[24:22], w[28:27]});
        check({probe_lo, probe_valid}, {2{w[28:27] == 2'h0}});
        check({pin_en, flag_oe, release_bit}, {w[25], !w[25], w[25]});
        check({tb_high, tb26, tb_low}, {w[31:29], w[26], w[15:10]});
    endtask : check_all

    task automatic write_word(input logic [31:0] w);
        logic [31:0] rd;
        rxscw_host_model_inst.xfer({8'h00, w}, 32, rd);
        check(rd, prev);
        prev = w;
        check_all(w);
    endtask : write_word

    // ======
    // Test sequence
    initial begin
        logic [31:0] rd;
        repeat (16) @(posedge i_clk);
        #1 i_reset = 1'b0;
        prev = WORD_RESET;
        check_all(WORD_RESET);
        $display("test reset values done");
        // Test bits stay at reset values on every write
        for (int b = 0; b < 26; b++) begin
            if (b < 10 || b > 15) begin
                write_word(WORD_RESET | (32'h1 << b));
            end
        end
        write_word(32'h1bff_cfff);
        $display("test single fields done");
        for (int c = 0; c < 8; c++) begin
            write_word(WORD_RESET | {3'h0, c[1:0], 1'b0, c[0], c[2:0], 22'h0});
        end
        $display("test selector codes done");
        rxscw_host_model_inst.xfer(40'h00_0000_0001, 31, rd);
        check(rd, prev);
        check_all(prev);
        rxscw_host_model_inst.xfer(40'h01_0000_ffff, 33, rd);
        check(rd, prev);
        check_all(prev);
        rxscw_host_model_inst.stray_clocks(8);
        check_all(prev);
        $display("test refused frames done");
        for (int ch = 0; ch < 5; ch++) begin
            @(posedge i_clk);
            #1 i_sat_detect = (ch < 4) ? (4'h1 << ch) : 4'h0;
            repeat (4) @(posedge i_clk);
            #1 check(sat_flag, ch < 4);
        end
        $display("test saturation flag done");
        write_word(32'h0040_cc01);
        @(posedge i_clk);
        #1 i_reset = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 i_reset = 1'b0;
        check_all(WORD_RESET);
        prev = WORD_RESET;
        write_word(32'h0260_cc00);
        $display("test second reset done");
        print_verdict();
    end

    // Whole sequence needs about 300 us
    initial begin
        #800000;
        err_total++;
        print_verdict();
    end
endmodule : test_receiver_serial_control_word
